// ---- hdl/vectored_interrupt_unit.sv ----
// vectored interrupt unit: event flags, masking, priority vectoring, shadow
// Function
// - any port six pin level change sets the pin change flag while its mask bit is set
// - pin change wakes from sleep if enabled before sleep entry
// - wake with interrupts disabled resumes after sleep, no vector
// - wake with interrupts enabled vectors to 006H
// - external pin pulses shorter than 8 clocks are rejected
// - low crystal mode bypasses the external pin noise filter
// - edge select bit picks the external pin active edge
// - enabled external interrupt vectors to 003H
// - enable instruction sets, disable instruction clears global enable
// - flags other than pin change set regardless of mask and enable
// - flag register read returns flags AND mask
// - return instruction sets global enable like the enable instruction
// - main timer and pwm timers vector to 009H, 012H, 015H, 018H
// - converter 00CH, comparator 00FH, low voltage 01BH
// - priority: lvd, ext, pin change, timer, adc, cmp, pwm1..3
// - save accumulator, status, memory select on entry; restore on return
// - shadow is one level; a nested entry overwrites it
// - pwm timer count matching its period raises its request
// - comparator output change raises its request
`timescale 1ns/10ps
module vectored_interrupt_unit #(
  parameter int unsigned NOISE_CYCLES = vint_pkg::NOISE_REJECT_CYCLES
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // axi4-lite register slave
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // event sources on the same clock
  input wire logic MAIN_TIMER_COUNTER_OVF_I,
  input wire logic ADC_DONE_I,
  input wire logic LVD_EVENT_I,
  input wire logic [2:0] PWM_MODE_I,
  input wire logic [2:0][vint_pkg::PWM_W-1:0] PWM_TIMER_COUNTS_I,
  input wire logic [2:0][vint_pkg::PWM_W-1:0] PWM_PERIOD_VALUES_I,
  // asynchronous pins
  input wire logic [7:0] PORT_SIX_DATA_I,
  input wire logic EXTERNAL_IRQ_PIN_I,
  input wire logic CMP_OUT_I,
  // processor core
  input wire logic ENABLE_INTERRUPTS_INSTR_I,
  input wire logic DISABLE_INTERRUPTS_INSTR_I,
  input wire logic RETURN_FROM_ISR_INSTR_I,
  input wire logic SLEEP_INSTR_I,
  input wire logic [7:0] ACCUMULATOR_REG_I,
  input wire logic [7:0] CORE_STATUS_REGISTER_I,
  input wire logic [7:0] MEMORY_SELECT_REGISTER_I,
  output logic VECTOR_VALID_O,
  output logic [vint_pkg::VEC_W-1:0] VECTOR_ADDR_O,
  output logic CORE_WAKE_O,
  output logic RESTORE_VALID_O,
  output logic [7:0] ACC_SAVED_O,
  output logic [7:0] STATUS_SAVED_O,
  output logic [7:0] MEMSEL_SAVED_O,
  output logic GIE_O,
  output logic SLEEPING_O
);

  if (NOISE_CYCLES < 1 || NOISE_CYCLES > 255) begin : g_bad_noise
    $error("NOISE_CYCLES must lie in 1..255");
  end

  localparam logic [7:0] NOISE_LAST = 8'(NOISE_CYCLES - 1);

  vint_pkg::vint_state_t r;
  vint_pkg::vint_state_t next_r;
  logic [vint_pkg::FLAG_W-1:0] pending;

  assign pending = r.flags & r.mask;

  always_comb begin
    logic [vint_pkg::FLAG_W-1:0] set_f;
    logic [vint_pkg::FLAG_W-1:0] clr_f;
    logic [2:0] match_now;
    logic wr_go;
    logic rd_go;
    logic pin_chg;
    logic ext_edge;
    logic take;
    logic [3:0] sel;
    set_f = '0;
    clr_f = '0;
    match_now = '0;
    sel = vint_pkg::F_TIMER;
    take = 1'b0;
    pin_chg = 1'b0;
    ext_edge = 1'b0;
    next_r = r;
    wr_go = r.awready && S_AXI_AWVALID_I && S_AXI_WVALID_I;
    rd_go = r.arready && S_AXI_ARVALID_I;

    // two-stage synchronisers
    next_r.p6_s1 = PORT_SIX_DATA_I;
    next_r.p6_s2 = r.p6_s1;
    next_r.ext_s1 = EXTERNAL_IRQ_PIN_I;
    next_r.ext_s2 = r.ext_s1;
    next_r.cmp_s1 = CMP_OUT_I;
    next_r.cmp_s2 = r.cmp_s1;

    // pin change against the reference latched on each change and on read
    pin_chg = (r.p6_s2 != r.p6_ref);
    if (pin_chg) begin
      next_r.p6_ref = r.p6_s2;
    end
    if (r.mask[vint_pkg::F_PINCHG] && pin_chg) begin
      set_f[vint_pkg::F_PINCHG] = 1'b1;
    end

    // external pin noise filter: level must hold NOISE_CYCLES clocks
    if (r.low_crystal_mode) begin
      next_r.ext_filt = r.ext_s2;
      next_r.ext_cnt = '0;
    end else if (r.ext_s2 == r.ext_filt) begin
      next_r.ext_cnt = '0;
    end else if (r.ext_cnt == NOISE_LAST) begin
      next_r.ext_filt = r.ext_s2;
      next_r.ext_cnt = '0;
    end else begin
      next_r.ext_cnt = 8'(r.ext_cnt + 8'h01);
    end
    ext_edge = r.edge_sel ? (r.ext_filt && !next_r.ext_filt)
                          : (!r.ext_filt && next_r.ext_filt);
    set_f[vint_pkg::F_EXT] = ext_edge;

    // comparator change
    next_r.cmp_prev = r.cmp_s2;
    set_f[vint_pkg::F_CMP] = (r.cmp_s2 != r.cmp_prev);

    // pwm period match, one event per match onset
    for (int i = 0; i < 3; i++) begin
      match_now[i] = PWM_MODE_I[i]
                     && (PWM_TIMER_COUNTS_I[i] == PWM_PERIOD_VALUES_I[i]);
    end
    next_r.pwm_match = match_now;
    set_f[vint_pkg::F_PWM1] = match_now[0] && !r.pwm_match[0];
    set_f[vint_pkg::F_PWM2] = match_now[1] && !r.pwm_match[1];
    set_f[vint_pkg::F_PWM3] = match_now[2] && !r.pwm_match[2];

    set_f[vint_pkg::F_TIMER] = MAIN_TIMER_COUNTER_OVF_I;
    set_f[vint_pkg::F_ADC] = ADC_DONE_I;
    set_f[vint_pkg::F_LVD] = LVD_EVENT_I;

    // axi write channel
    next_r.awready = S_AXI_AWVALID_I && S_AXI_WVALID_I && !r.bvalid
                     && !r.awready;
    next_r.wready = next_r.awready;
    if (r.bvalid && S_AXI_BREADY_I) begin
      next_r.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_r.bvalid = 1'b1;
      next_r.bresp = vint_pkg::RESP_OKAY;
      unique case (S_AXI_AWADDR_I)
        vint_pkg::ADDR_FLAG: begin
          if (S_AXI_WSTRB_I[0]) begin
            clr_f[7:0] = S_AXI_WDATA_I[7:0];
          end
          if (S_AXI_WSTRB_I[1]) begin
            clr_f[8] = S_AXI_WDATA_I[8];
          end
        end
        vint_pkg::ADDR_MASK: begin
          if (S_AXI_WSTRB_I[0]) begin
            next_r.mask[7:0] = S_AXI_WDATA_I[7:0];
          end
          if (S_AXI_WSTRB_I[1]) begin
            next_r.mask[8] = S_AXI_WDATA_I[8];
          end
        end
        vint_pkg::ADDR_CTRL: begin
          if (S_AXI_WSTRB_I[0]) begin
            next_r.edge_sel = S_AXI_WDATA_I[vint_pkg::CTRL_EDGE];
            next_r.low_crystal_mode = S_AXI_WDATA_I[vint_pkg::CTRL_LOW_XTAL];
          end
        end
        vint_pkg::ADDR_PORT6: begin
        end
        default: begin
          next_r.bresp = vint_pkg::RESP_SLVERR;
        end
      endcase
    end
    // set wins over a simultaneous clear
    next_r.flags = (r.flags & ~clr_f) | set_f;

    // axi read channel
    next_r.arready = S_AXI_ARVALID_I && !r.rvalid && !r.arready;
    if (r.rvalid && S_AXI_RREADY_I) begin
      next_r.rvalid = 1'b0;
    end
    if (rd_go) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = vint_pkg::RESP_OKAY;
      next_r.rdata = '0;
      unique case (S_AXI_ARADDR_I)
        vint_pkg::ADDR_FLAG: begin
          next_r.rdata[vint_pkg::FLAG_W-1:0] = pending;
        end
        vint_pkg::ADDR_MASK: begin
          next_r.rdata[vint_pkg::FLAG_W-1:0] = r.mask;
        end
        vint_pkg::ADDR_CTRL: begin
          next_r.rdata[vint_pkg::CTRL_EDGE] = r.edge_sel;
          next_r.rdata[vint_pkg::CTRL_LOW_XTAL] = r.low_crystal_mode;
          next_r.rdata[vint_pkg::CTRL_GIE] = r.gie;
          next_r.rdata[vint_pkg::CTRL_SLEEP] = (r.core == vint_pkg::CORE_SLEEP);
        end
        vint_pkg::ADDR_PORT6: begin
          next_r.rdata[7:0] = r.p6_s2;
          next_r.p6_ref = r.p6_s2;
        end
        default: begin
          next_r.rresp = vint_pkg::RESP_SLVERR;
        end
      endcase
    end

    // global enable from the core's instructions
    if (DISABLE_INTERRUPTS_INSTR_I) begin
      next_r.gie = 1'b0;
    end
    if (ENABLE_INTERRUPTS_INSTR_I || RETURN_FROM_ISR_INSTR_I) begin
      next_r.gie = 1'b1;
    end
    next_r.restore = RETURN_FROM_ISR_INSTR_I;

    // sleep and pin change wake-up
    next_r.wake = 1'b0;
    unique case (r.core)
      vint_pkg::CORE_RUN: begin
        if (SLEEP_INSTR_I) begin
          next_r.core = vint_pkg::CORE_SLEEP;
          next_r.sleep_pc_en = r.mask[vint_pkg::F_PINCHG];
        end
      end
      vint_pkg::CORE_SLEEP: begin
        if (pin_chg && r.sleep_pc_en) begin
          next_r.core = vint_pkg::CORE_RUN;
          next_r.wake = 1'b1;
        end
      end
    endcase

    // highest pending request wins
    for (int i = 8; i >= 0; i--) begin
      if (pending[vint_pkg::PRIO_ORDER[i]]) begin
        sel = vint_pkg::PRIO_ORDER[i];
      end
    end
    take = r.gie && (pending != '0) && (r.core == vint_pkg::CORE_RUN)
           && !r.vec_valid;
    next_r.vec_valid = take;
    if (take) begin
      next_r.vec_addr = vint_pkg::VEC_ADDR[sel];
      next_r.gie = 1'b0;
      next_r.acc_sv = ACCUMULATOR_REG_I;
      next_r.stat_sv = CORE_STATUS_REGISTER_I;
      next_r.msel_sv = MEMORY_SELECT_REGISTER_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      r <= '0;
      r.mask <= vint_pkg::MASK_RESET;
      r.core <= vint_pkg::CORE_RUN;
      // pins keep settling through reset, so no false edge follows release
      r.p6_s1 <= next_r.p6_s1;
      r.p6_s2 <= r.p6_s1;
      r.p6_ref <= r.p6_s2;
      r.ext_s1 <= next_r.ext_s1;
      r.ext_s2 <= r.ext_s1;
      r.ext_filt <= r.ext_s2;
      r.cmp_s1 <= next_r.cmp_s1;
      r.cmp_s2 <= r.cmp_s1;
      r.cmp_prev <= r.cmp_s2;
    end else begin
      r <= next_r;
    end
  end

  assign S_AXI_AWREADY_O = r.awready;
  assign S_AXI_WREADY_O = r.wready;
  assign S_AXI_BRESP_O = r.bresp;
  assign S_AXI_BVALID_O = r.bvalid;
  assign S_AXI_ARREADY_O = r.arready;
  assign S_AXI_RDATA_O = r.rdata;
  assign S_AXI_RRESP_O = r.rresp;
  assign S_AXI_RVALID_O = r.rvalid;
  assign VECTOR_VALID_O = r.vec_valid;
  assign VECTOR_ADDR_O = r.vec_addr;
  assign CORE_WAKE_O = r.wake;
  assign RESTORE_VALID_O = r.restore;
  assign ACC_SAVED_O = r.acc_sv;
  assign STATUS_SAVED_O = r.stat_sv;
  assign MEMSEL_SAVED_O = r.msel_sv;
  assign GIE_O = r.gie;
  assign SLEEPING_O = (r.core == vint_pkg::CORE_SLEEP);

  // checks
  vector_clears_gie_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    VECTOR_VALID_O |-> !GIE_O && $past(GIE_O))
    else $error("vector taken without clearing global enable");

  enable_sets_gie_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    ENABLE_INTERRUPTS_INSTR_I && !GIE_O |=> GIE_O)
    else $error("enable instruction did not set global enable");

  disable_clears_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    DISABLE_INTERRUPTS_INSTR_I && !ENABLE_INTERRUPTS_INSTR_I
    && !RETURN_FROM_ISR_INSTR_I |=> !GIE_O)
    else $error("disable instruction did not clear global enable");

  return_restores_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    RETURN_FROM_ISR_INSTR_I && !GIE_O
    |=> RESTORE_VALID_O && GIE_O && $stable(ACC_SAVED_O))
    else $error("return did not restore and re-enable");

  shadow_capture_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    $rose(VECTOR_VALID_O) |-> ACC_SAVED_O == $past(ACCUMULATOR_REG_I)
    && MEMSEL_SAVED_O == $past(MEMORY_SELECT_REGISTER_I))
    else $error("shadow registers not captured on entry");

  timer_flag_set_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    MAIN_TIMER_COUNTER_OVF_I |=> r.flags[vint_pkg::F_TIMER])
    else $error("timer overflow flag not set");

  flag_read_masked_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    S_AXI_ARVALID_I && S_AXI_ARREADY_O
    && S_AXI_ARADDR_I == vint_pkg::ADDR_FLAG
    |=> S_AXI_RDATA_O == 32'($past(r.flags & r.mask)))
    else $error("flag read not masked");

  noise_filter_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    $changed(r.ext_filt) && !$past(r.low_crystal_mode)
    |-> $past(r.ext_cnt) == NOISE_LAST)
    else $error("external pin accepted a short pulse");

  lvd_priority_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    $rose(VECTOR_VALID_O) && $past(pending[vint_pkg::F_LVD])
    |-> VECTOR_ADDR_O == vint_pkg::VEC_ADDR[vint_pkg::F_LVD])
    else $error("low voltage request not served first");

  wake_from_sleep_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    CORE_WAKE_O |-> !SLEEPING_O && $past(SLEEPING_O)
    && $past(r.sleep_pc_en))
    else $error("wake without enabled sleep");

  wake_no_vector_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    CORE_WAKE_O && !GIE_O |=> !VECTOR_VALID_O)
    else $error("vector taken after wake with interrupts disabled");

  cmp_change_flag_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    r.cmp_s2 != r.cmp_prev |=> r.flags[vint_pkg::F_CMP])
    else $error("comparator change did not set its flag");

endmodule

// ---- shared/vint_pkg.sv ----
// shared constants, types and state layout of the vectored interrupt unit
package vint_pkg;

  // flag and mask bit positions
  localparam int unsigned FLAG_W = 9;
  localparam logic [3:0] F_TIMER = 4'h0;
  localparam logic [3:0] F_PINCHG = 4'h1;
  localparam logic [3:0] F_EXT = 4'h2;
  localparam logic [3:0] F_ADC = 4'h3;
  localparam logic [3:0] F_PWM1 = 4'h4;
  localparam logic [3:0] F_PWM2 = 4'h5;
  localparam logic [3:0] F_PWM3 = 4'h6;
  localparam logic [3:0] F_CMP = 4'h7;
  localparam logic [3:0] F_LVD = 4'h8;

  // service order, highest first
  localparam logic [3:0] PRIO_ORDER [0:8] = '{
    F_LVD, F_EXT, F_PINCHG, F_TIMER, F_ADC, F_CMP, F_PWM1, F_PWM2, F_PWM3
  };

  // vector address per flag index
  localparam int unsigned VEC_W = 10;
  localparam logic [9:0] VEC_ADDR [0:8] = '{
    10'h009, 10'h006, 10'h003, 10'h00C, 10'h012,
    10'h015, 10'h018, 10'h00F, 10'h01B
  };

  // register byte addresses
  localparam logic [7:0] ADDR_FLAG = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_PORT6 = 8'h0C;

  // control register fields
  localparam int unsigned CTRL_EDGE = 0;
  localparam int unsigned CTRL_LOW_XTAL = 1;
  localparam int unsigned CTRL_GIE = 2;
  localparam int unsigned CTRL_SLEEP = 3;

  localparam logic [FLAG_W-1:0] MASK_RESET = 9'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned NOISE_REJECT_CYCLES = 8;
  localparam int unsigned PWM_W = 10;

  typedef enum logic {CORE_RUN = 1'b0, CORE_SLEEP = 1'b1} core_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] mask;
    logic edge_sel;
    logic low_crystal_mode;
    logic gie;
    core_state_t core;
    logic sleep_pc_en;
    logic [7:0] p6_s1;
    logic [7:0] p6_s2;
    logic [7:0] p6_ref;
    logic ext_s1;
    logic ext_s2;
    logic ext_filt;
    logic [7:0] ext_cnt;
    logic cmp_s1;
    logic cmp_s2;
    logic cmp_prev;
    logic [2:0] pwm_match;
    logic vec_valid;
    logic [VEC_W-1:0] vec_addr;
    logic wake;
    logic restore;
    logic [7:0] acc_sv;
    logic [7:0] stat_sv;
    logic [7:0] msel_sv;
  } vint_state_t;

endpackage

// ---- test/core_partner.sv ----
// core model: instruction strobes and an accumulator with shadow restore
`timescale 1ns/10ps
module core_partner (
  // clock and requests from the bench
  input wire logic clk_i,
  input wire logic [2:0] op_i,
  input wire logic load_i,
  input wire logic [7:0] val_i,
  // shadow restore from the block
  input wire logic restore_i,
  input wire logic [7:0] acc_sv_i,
  // core outputs
  output logic [3:0] instr_o,
  output logic [7:0] acc_o
);
  // op 1..4: enable, disable, return, sleep strobes
  assign instr_o = (op_i == 3'h0) ? 4'h0 : 4'h1 << (op_i - 3'h1);
  always @(posedge clk_i) begin
    if (restore_i) begin
      acc_o <= acc_sv_i;
    end else if (load_i) begin
      acc_o <= val_i;
    end
  end
endmodule

// ---- test/tb_vectored_interrupt_unit.sv ----
// self-checking bench of the vectored interrupt unit
`timescale 1ns/10ps
module tb_vectored_interrupt_unit;
  localparam logic [7:0] a_flag = vint_pkg::ADDR_FLAG;
  localparam logic [7:0] a_mask = vint_pkg::ADDR_MASK;
  localparam logic [7:0] a_ctrl = vint_pkg::ADDR_CTRL;
  localparam logic [7:0] a_port = vint_pkg::ADDR_PORT6;
  localparam logic [1:0] okay = vint_pkg::RESP_OKAY;
  // service order, highest first, with flag bit and vector
  localparam logic [3:0] fb [9] = '{4'h8, 4'h2, 4'h1, 4'h0, 4'h3, 4'h7,
    4'h4, 4'h5, 4'h6};
  localparam logic [9:0] va [9] = '{10'h01B, 10'h003, 10'h006, 10'h009,
    10'h00C, 10'h00F, 10'h012, 10'h015, 10'h018};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic tmr = 1'b0, adc = 1'b0, lvd = 1'b0, ext = 1'b0, cmp = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [2:0][9:0] cnt = 30'h0, prd = 30'h0;
  logic [7:0] p6 = 8'h00;
  logic [2:0] op = 3'h0;
  logic load = 1'b0;
  logic [7:0] val = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, vvalid, wake, restore;
  logic gie, sleeping;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] vaddr;
  logic [7:0] acc_sv, stat_sv, msel_sv, acc, av;
  logic [3:0] instr;
  logic [2:0] k;
  logic [34:0] rdq [$];
  logic [33:0] vq [$];
  logic [1:0] bq [$];
  logic [34:0] e;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  vectored_interrupt_unit #(.NOISE_CYCLES(8)) dut_u (
    .CLK_I(clk), .SRST_I(srst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .MAIN_TIMER_COUNTER_OVF_I(tmr), .ADC_DONE_I(adc), .LVD_EVENT_I(lvd),
    .PWM_MODE_I(mode), .PWM_TIMER_COUNTS_I(cnt), .PWM_PERIOD_VALUES_I(prd),
    .PORT_SIX_DATA_I(p6), .EXTERNAL_IRQ_PIN_I(ext), .CMP_OUT_I(cmp),
    .ENABLE_INTERRUPTS_INSTR_I(instr[0]),
    .DISABLE_INTERRUPTS_INSTR_I(instr[1]),
    .RETURN_FROM_ISR_INSTR_I(instr[2]), .SLEEP_INSTR_I(instr[3]),
    .ACCUMULATOR_REG_I(acc), .CORE_STATUS_REGISTER_I(~acc),
    .MEMORY_SELECT_REGISTER_I(acc ^ 8'h5A),
    .VECTOR_VALID_O(vvalid), .VECTOR_ADDR_O(vaddr), .CORE_WAKE_O(wake),
    .RESTORE_VALID_O(restore), .ACC_SAVED_O(acc_sv),
    .STATUS_SAVED_O(stat_sv), .MEMSEL_SAVED_O(msel_sv),
    .GIE_O(gie), .SLEEPING_O(sleeping)
  );

  core_partner core_u (
    .clk_i(clk), .op_i(op), .load_i(load), .val_i(val),
    .restore_i(restore), .acc_sv_i(acc_sv), .instr_o(instr), .acc_o(acc)
  );

  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string n, input logic [33:0] x,
                       input logic [33:0] g);
    num_checks++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", n, x, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = okay);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (!awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  // the monitor compares the response, and the data of OKAY reads, against the note queued here
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = okay);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rdq.push_back({r == okay, r, d});
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic do_op(input logic [2:0] o);
    op <= o;
    @(posedge clk);
    op <= 3'h0;
  endtask

  task automatic ld(input logic [7:0] v);
    val <= v;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask

  task automatic pulse_ext(input int n);
    ext <= 1'b1;
    tick(n);
    ext <= 1'b0;
    tick(16);
  endtask

  always @(posedge clk) begin
    if (bvalid && bready) begin
      check("bresp", 34'(bq.pop_front()), 34'(bresp));
    end
    if (rvalid && rready) begin
      e = rdq.pop_front();
      check("rresp", 34'(e[33:32]), 34'(rresp));
      if (e[34]) check("rdata", 34'(e[31:0]), 34'(rdata));
    end
    if (vvalid) begin
      if (vq.size() == 0) check("stray vector", 34'h0, 34'h1);
      else check("vector", vq.pop_front(), {vaddr, acc_sv, stat_sv, msel_sv});
      check("gie at vector", 34'h0, 34'(gie));
    end
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(32'hFBDC));
    p6 <= 8'($urandom);
    prd <= 30'($urandom) | 30'h00100401;
    tick(16);
    srst <= 1'b0;
    ld(8'h00);
    rd(a_mask, 32'h0);
    rd(a_ctrl, 32'h0);
    rd(8'h10, 32'h0, vint_pkg::RESP_SLVERR);
    wr(8'h10, 32'h1FF, vint_pkg::RESP_SLVERR);
    wr(a_port, 32'hFF);
    av = 8'($urandom);
    wr(a_mask, {23'h0, av, 1'b1});
    rd(a_mask, {23'h0, av, 1'b1});
    wr(a_ctrl, 32'hF);
    rd(a_ctrl, 32'h3);
    wr(a_ctrl, 32'h0);
    // timer flag set while masked, pin change flag not; read shows flags and mask
    wr(a_mask, 32'h0);
    tmr <= 1'b1;
    p6[0] <= ~p6[0];
    tick(1);
    tmr <= 1'b0;
    tick(2);
    rd(a_flag, 32'h0);
    wr(a_mask, 32'h3);
    rd(a_flag, 32'h1);
    wr(a_flag, 32'h1);
    rd(a_flag, 32'h0);
    // external pin filter, edge select and bypass
    wr(a_mask, 32'h4);
    pulse_ext(7);
    rd(a_flag, 32'h0);
    pulse_ext(8);
    rd(a_flag, 32'h4);
    wr(a_flag, 32'h4);
    wr(a_ctrl, 32'h1);
    ext <= 1'b1;
    tick(16);
    rd(a_flag, 32'h0);
    ext <= 1'b0;
    tick(16);
    rd(a_flag, 32'h4);
    wr(a_flag, 32'h4);
    wr(a_ctrl, 32'h2);
    pulse_ext(2);
    rd(a_flag, 32'h4);
    wr(a_flag, 32'h4);
    wr(a_ctrl, 32'h0);
    // each port six pin alone
    rd(a_port, {24'h0, p6});
    wr(a_mask, 32'h2);
    for (int i = 0; i < 8; i++) begin
      p6[i] <= ~p6[i];
      tick(6);
      rd(a_flag, 32'h2);
      wr(a_flag, 32'h2);
    end
    // sleep and wake, first with interrupts off, then on
    k = 3'($urandom);
    do_op(3'h4);
    tick(1);
    check("sleeping", 34'h1, 34'(sleeping));
    p6[k] <= ~p6[k];
    do @(posedge clk); while (!wake);
    check("sleeping", 34'h0, 34'(sleeping));
    tick(4);
    rd(a_flag, 32'h2);
    wr(a_flag, 32'h2);
    av = 8'($urandom);
    ld(av);
    vq.push_back({10'h006, av, ~av, av ^ 8'h5A});
    do_op(3'h1);
    tick(1);
    check("gie", 34'h1, 34'(gie));
    do_op(3'h4);
    tick(2);
    p6[k] <= ~p6[k];
    do @(posedge clk); while (!vvalid);
    wr(a_flag, 32'h2);
    do_op(3'h3);
    tick(1);
    check("gie", 34'h1, 34'(gie));
    do_op(3'h2);
    tick(1);
    check("gie", 34'h0, 34'(gie));
    // all sources at once, served one by one in priority
    rd(a_port, {24'h0, p6});
    wr(a_mask, 32'h1FF);
    mode <= 3'h7;
    tick(1);
    {tmr, adc, lvd, ext} <= 4'hF;
    cnt <= prd;
    cmp <= ~cmp;
    p6[0] <= ~p6[0];
    tick(1);
    {tmr, adc, lvd} <= 3'h0;
    cnt <= 30'h0;
    tick(12);
    ext <= 1'b0;
    tick(4);
    rd(a_flag, 32'h1FF);
    for (int i = 0; i < 9; i++) begin
      av = 8'($urandom);
      ld(av);
      vq.push_back({va[i], av, ~av, av ^ 8'h5A});
      do_op(i == 0 ? 3'h1 : 3'h3);
      do @(posedge clk); while (!vvalid);
      wr(a_flag, 32'h1 << fb[i]);
    end
    ld(~av);
    do_op(3'h3);
    tick(3);
    check("restored acc", 34'(av), 34'(acc));
    complete_run();
  end
endmodule
